/* inc/sdd_pkg.sv */
// Constants and register layout for the sigma-delta DAC control block.
// Assumes a register port that presents whole decoded words with a write strobe.
// What this block does
// RULE1 - The level register at 0x0A holds value bits 16:9 in 23:16, 8:1 in 15:8 and bit 0 in bit 7.
// RULE2 - A write to the level register loads the 17-bit value as the modulator's new input.
// RULE3 - After reset the modulator is off and the level shows at the output only once enabled.
// RULE4 - The output is a one-bit stream switching between ground and the reference.
// RULE5 - A detected clock failure forces the output to the level picked by the fallback pin.
// RULE6 - The forced level holds until reset or a rising edge on the kick pin while no clock failure is flagged.
// RULE7 - Bit 0 of the analog configuration register at 0x03 enables the DAC when 0 and resets to 1.
// RULE8 - With the kick-source field at 10, each level write also counts as a watchdog kick.
// RULE9 - The host writes the inverse of an analog configuration value to the shadow register first.
// RULE10 - Level register bits 6:0 ignore writes and read back as zero.
package sdd_pkg;
	localparam logic [7:0] SDD_LEVEL_ADDR = 8'h0A;
	localparam logic [7:0] SDD_ACR_ADDR = 8'h03;
	localparam int SDD_LEVEL_W = 24;
	localparam int SDD_VAL_W = 17;
	localparam int SDD_VAL_HI_POS = 16;
	localparam int SDD_VAL_LO_POS = 7;
	localparam int SDD_ACR_EN_POS = 0;
	localparam logic [23:0] SDD_LEVEL_RESET = 24'h000000;
	localparam logic SDD_EN_N_RESET = 1'h1;
	localparam logic [1:0] SDD_KICK_SRC_LEVEL = 2'h2;
	typedef enum logic [1:0] {
		SDD_RUN = 2'h1,
		SDD_FORCED = 2'h2
	} sdd_state_t;
endpackage

/* design/sdd_dac_ctrl.sv */
// Sigma-delta DAC control: level register, first-order modulator, fallback override.
// Assumes register writes arrive decoded as address, word and one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module sdd_dac_ctrl (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [sdd_pkg::SDD_LEVEL_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic [1:0] i_kick_src,
	input wire logic i_clk_fail,
	input wire logic i_fallback_level,
	input wire logic i_kick,
	output logic [sdd_pkg::SDD_LEVEL_W-1:0] o_rdata,
	output logic o_dac_enable_n,
	output logic o_dac_out,
	output logic o_forced,
	output logic o_watchdog_kick_source
);
	import sdd_pkg::*;

	// ==========================================
	// Registers
	logic [SDD_VAL_W-1:0] level_reg, level_next;
	logic en_n_reg, en_n_next;
	logic [SDD_VAL_W-1:0] acc_reg, acc_next;
	logic out_reg, out_next;
	logic kick_reg;
	sdd_state_t state_reg, state_next;
	logic [SDD_VAL_W:0] sum;
	logic wr_level;
	logic kick_rise;
	logic watchdog_kick_source_next;

	// ==========================================
	// Write decode and kick edge
	// Kick edge comes from the previous sample of the pin.
	// A pin already high at reset release reads as an edge,
	// harmless since the block always leaves reset running.
	assign wr_level = i_wr && (i_addr == SDD_LEVEL_ADDR);
	assign kick_rise = i_kick && !kick_reg;

	// ==========================================
	// Watchdog kick
	// Only a level write qualifies; other sources live elsewhere
	always_comb begin
		watchdog_kick_source_next = wr_level && (i_kick_src == SDD_KICK_SRC_LEVEL); // see RULE8
	end

	// ==========================================
	// Register writes
	// Bits below the value field are dropped on write

	always_comb begin
		level_next = level_reg;
		en_n_next = en_n_reg;
		if (wr_level) begin
			level_next = i_wdata[SDD_VAL_HI_POS+7:SDD_VAL_LO_POS]; // see RULE1 see RULE2
		end
		if (i_wr && (i_addr == SDD_ACR_ADDR)) begin
			en_n_next = i_wdata[SDD_ACR_EN_POS]; // see RULE7
		end
	end

	// ==========================================
	// Modulator and fallback
	always_comb begin
		sum = {1'b0, acc_reg} + {1'b0, level_reg};
		acc_next = acc_reg;
		out_next = 1'b0;
		state_next = state_reg;
		unique case (state_reg)
			SDD_RUN: begin
				if (i_clk_fail) begin
					state_next = SDD_FORCED; // see RULE5
				end
			end
			SDD_FORCED: begin
				if (kick_rise && !i_clk_fail) begin
					state_next = SDD_RUN; // see RULE6
				end
			end
			default: state_next = SDD_RUN;
		endcase
		if (state_next == SDD_FORCED) begin
			out_next = i_fallback_level; // see RULE5
		end else if (!en_n_reg) begin
			// Carry out of the accumulator is the bitstream
			acc_next = sum[SDD_VAL_W-1:0];
			out_next = sum[SDD_VAL_W]; // see RULE4
		end else begin
			acc_next = '0; // see RULE3
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			level_reg <= '0;
			en_n_reg <= SDD_EN_N_RESET;
			acc_reg <= '0;
			out_reg <= 1'b0;
			kick_reg <= 1'b0;
			state_reg <= SDD_RUN;
			o_watchdog_kick_source <= 1'b0;
		end else begin
			level_reg <= level_next;
			en_n_reg <= en_n_next;
			acc_reg <= acc_next;
			out_reg <= out_next;
			kick_reg <= i_kick;
			state_reg <= state_next;
			o_watchdog_kick_source <= watchdog_kick_source_next; // see RULE8
		end
	end

	always_comb begin
		o_rdata = '0;
		if (i_addr == SDD_LEVEL_ADDR) begin
			o_rdata = {level_reg, 7'h00}; // see RULE10
		end else if (i_addr == SDD_ACR_ADDR) begin
			o_rdata = {23'h000000, en_n_reg};
		end
	end

	assign o_dac_out = out_reg;
	assign o_dac_enable_n = en_n_reg;
	assign o_forced = (state_reg == SDD_FORCED);

	// ==========================================
	// Checks: enable and quiet output
	AST_OFF_LOW: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE3
		en_n_reg && !o_forced && $past(en_n_reg) |-> !o_dac_out)
		else $error("output active while disabled");

	AST_DIS_QUIET: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE3
		en_n_reg && !o_forced && !i_clk_fail |=> !o_dac_out)
		else $error("output rose while disabled");

	// Zero level never carries, so the stream must stay low
	AST_ZERO_QUIET: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE4
		!o_forced && !i_clk_fail && level_reg == '0 |=> !o_dac_out)
		else $error("stream high at zero level");

	// ==========================================
	// Checks: fallback
	AST_FAIL_FORCE: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE5
		i_clk_fail |=> o_forced && o_dac_out == $past(i_fallback_level))
		else $error("clock failure not forced");

	AST_FORCED_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE5
		o_forced |-> o_dac_out == $past(i_fallback_level))
		else $error("forced output not the fallback level");

	AST_RUN_STAYS: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE5
		!o_forced && !i_clk_fail |=> !o_forced)
		else $error("forced without clock failure");

	AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE6
		o_forced && !i_kick |=> o_forced)
		else $error("fallback released without kick");

	AST_RELEASE: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE6
		o_forced && i_kick && !$past(i_kick) && !i_clk_fail |=> !o_forced)
		else $error("kick did not release");

	// Illegal codes fall back to running, but must never be seen
	AST_STATE_LEGAL: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE6
		$onehot(state_reg))
		else $error("state code not one-hot");

	// ==========================================
	// Checks: register writes and reads
	AST_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE1
		i_wr && i_addr == SDD_LEVEL_ADDR
		|=> level_reg == $past(i_wdata[SDD_VAL_HI_POS+7:SDD_VAL_LO_POS]))
		else $error("level not loaded");

	AST_OTHER_ADDR: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE2
		i_wr && i_addr != SDD_LEVEL_ADDR |=> $stable(level_reg))
		else $error("level changed by a foreign write");

	AST_EN: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE7
		i_wr && i_addr == SDD_ACR_ADDR |=> o_dac_enable_n == $past(i_wdata[SDD_ACR_EN_POS]))
		else $error("enable not loaded");

	AST_EN_KEEP: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE7
		!(i_wr && i_addr == SDD_ACR_ADDR) |=> $stable(o_dac_enable_n))
		else $error("enable changed without a config write");

	AST_RD0: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE10
		i_addr == SDD_LEVEL_ADDR |-> o_rdata[6:0] == 7'h00)
		else $error("unused bits nonzero");

	// ==========================================
	// Checks: watchdog kick
	AST_KICK: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE8
		i_wr && i_addr == SDD_LEVEL_ADDR && i_kick_src == SDD_KICK_SRC_LEVEL |=> o_watchdog_kick_source)
		else $error("kick missing");

	AST_KICK_ONLY: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE8
		o_watchdog_kick_source |-> $past(i_wr) && $past(i_addr) == SDD_LEVEL_ADDR
		&& $past(i_kick_src) == SDD_KICK_SRC_LEVEL)
		else $error("kick without a qualifying write");

	AST_SRC_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn) // see RULE8
		i_kick_src != SDD_KICK_SRC_LEVEL |=> !o_watchdog_kick_source)
		else $error("kick with another source selected");

	// ==========================================
	// Coverage of the main scenarios
	COV_RUN: cover property (@(posedge i_clk) !en_n_reg && o_dac_out);
	COV_FORCE: cover property (@(posedge i_clk) o_forced);
	COV_REL: cover property (@(posedge i_clk) o_forced ##1 !o_forced);
	COV_KICK: cover property (@(posedge i_clk) o_watchdog_kick_source);
endmodule
`default_nettype wire

/* verif/sdd_host.sv */
// Host model: writes device registers as one-cycle strobes.
// Assumes the bench supplies the clock and has released reset.
`timescale 1ns/1ps
`default_nettype none
module sdd_host #(
	parameter logic [7:0] SHADOW_ADDR = 8'h0F
) (
	input wire logic i_clk,
	output logic [7:0] o_addr,
	output logic [23:0] o_wdata,
	output logic o_wr
);
	import sdd_pkg::*;
	// ====================
	// Register writes
	initial begin
		o_addr = 8'h00;
		o_wdata = 24'h000000;
		o_wr = 1'b0;
	end
	// Returns at a falling edge so callers sample settled outputs
	task automatic put(input logic [7:0] a, input logic [23:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		@(negedge i_clk);
	endtask
	task automatic cfg(input logic [23:0] d);
		put(SHADOW_ADDR, ~d);
		put(SDD_ACR_ADDR, d);
	endtask
endmodule
`default_nettype wire

/* verif/sdd_dac_ctrl_bench.sv */
// Bench for the DAC control block: level table, enable, kick and fallback.
// Assumes the host model is the only register writer.
`timescale 1ns/1ps
`default_nettype none
module sdd_dac_ctrl_bench;
	import sdd_pkg::*;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_wr, i_clk_fail = 1'b0, i_fallback_level = 1'b0, i_kick = 1'b0;
	logic [7:0] i_addr;
	logic [23:0] i_wdata, o_rdata;
	logic [1:0] i_kick_src = 2'h0;
	logic o_dac_enable_n, o_dac_out, o_forced, o_watchdog_kick_source;
	int miscompares = 0, n_checks = 0, cyc = 0, ones = 0;
	logic [47:0] rows [4] = '{48'hFFFFFF_FFFF80, 48'h00007F_000000,
		48'h123456_123400, 48'h000080_000080};
	sdd_host i_host (.i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr));
	sdd_dac_ctrl i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_kick_src(i_kick_src), .i_clk_fail(i_clk_fail),
		.i_fallback_level(i_fallback_level), .i_kick(i_kick), .o_rdata(o_rdata),
		.o_dac_enable_n(o_dac_enable_n), .o_dac_out(o_dac_out), .o_forced(o_forced),
		.o_watchdog_kick_source(o_watchdog_kick_source));
	// ====================
	// Clock, watchdog, helpers
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			results();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	task automatic results();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ====================
	// Sequence
	initial begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		tick(1);
		chk(24'(o_dac_enable_n), 24'h000001);
		foreach (rows[k]) begin
			i_host.put(SDD_LEVEL_ADDR, rows[k][47:24]);
			chk(o_rdata, rows[k][23:0]);
		end
		chk(24'(o_dac_out), 24'h000000);
		i_host.cfg(24'h000000);
		chk(24'(o_dac_enable_n), 24'h000000);
		@(posedge i_clk) i_kick_src <= SDD_KICK_SRC_LEVEL;
		i_host.put(SDD_LEVEL_ADDR, 24'h800000);
		chk(24'(o_watchdog_kick_source), 24'h000001);
		tick(2);
		chk(24'(o_watchdog_kick_source), 24'h000000);
		repeat (64) begin
			tick(1);
			ones += int'(o_dac_out);
		end
		chk(24'(ones), 24'h000020);
		@(posedge i_clk) i_clk_fail <= 1'b1;
		@(posedge i_clk) i_fallback_level <= 1'b1;
		tick(1);
		chk(24'({o_forced, o_dac_out}), 24'h000003);
		@(posedge i_clk) i_kick <= 1'b1;
		tick(2);
		chk(24'(o_forced), 24'h000001);
		@(posedge i_clk) i_clk_fail <= 1'b0;
		@(posedge i_clk) i_kick <= 1'b0;
		tick(4);
		chk(24'({o_forced, o_dac_out}), 24'h000003);
		@(posedge i_clk) i_kick <= 1'b1;
		tick(2);
		chk(24'(o_forced), 24'h000000);
		// Mid-run reset while forced: fallback and enable return to reset state
		@(posedge i_clk) i_clk_fail <= 1'b1;
		@(posedge i_clk) i_clk_fail <= 1'b0;
		tick(1);
		chk(24'(o_forced), 24'h000001);
		@(posedge i_clk) i_rstn <= 1'b0;
		tick(2);
		@(posedge i_clk) i_rstn <= 1'b1;
		tick(1);
		chk(24'({o_forced, o_dac_enable_n, o_dac_out}), 24'h000002);
		chk(o_rdata, 24'h000000);
		results();
	end
endmodule
`default_nettype wire
